// file: shared/msio_pkg.sv
// Shared constants and types for the module status and I/O control block.
package msio_pkg;
  localparam logic [7:0] ADDR_STATUS = 8'h6e;
  localparam logic [7:0] ADDR_PART_ID = 8'h86;
  localparam logic [7:0] ADDR_SI_REV = 8'h87;
  localparam logic [7:0] ADDR_CONFIG_A = 8'h88;
  localparam logic [7:0] ADDR_CONFIG_B = 8'h89;
  localparam logic [7:0] ADDR_CONFIG_C = 8'h8a;
  localparam logic [7:0] ADDR_BUS_SEL = 8'h8b;
  localparam logic [7:0] ADDR_FAULT_EN1 = 8'hf8;
  localparam logic [7:0] ADDR_FAULT_EN2 = 8'hfc;
  // Bus address answered before the stored one is recalled.
  localparam logic [7:0] DEFAULT_BUS_ADDR = 8'ha2;
  // Status byte field positions.
  localparam int ST_NOT_READY = 0;
  localparam int ST_RXL0 = 1;
  localparam int ST_RXL1 = 2;
  localparam int ST_LATCH_CLR = 3;
  localparam int ST_RATE_SELECT_INPUT_SOFT = 5;
  localparam int ST_GEN_IN = 6;
  localparam int ST_RATE_SELECT_INPUT_IN = 7;
  // Config A fields.
  localparam int CA_RATE_SELECT_INPUT_INV = 0;
  localparam int CA_RATE_SELECT_INPUT_PIN = 1;
  // Config B fields.
  localparam int CB_GEN_FORCE = 0;
  localparam int CB_GEN_FVAL = 1;
  localparam int CB_GEN_INV = 2;
  localparam int CB_GEN_SRC = 3;
  localparam int CB_LATCH_LO = 4;
  // Config C fields.
  localparam int CC_LOSS_SEL = 0;
  localparam int CC_LOSS_INV = 2;
  localparam int CC_LATCH_LO = 4;
  localparam int NUM_ALARMS = 6;
  localparam int NUM_FAULT_SRC = 16;
  localparam int FS_LOSS_QT = 12;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // Supply-ready settling time after the analog level is reached.
  localparam int READY_TIME_NS = 500000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int READY_CYCLES = READY_TIME_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  localparam int SYNC_W = 5;

  typedef struct packed {
    logic [7:0] config_a;
    logic [7:0] config_b;
    logic [7:0] config_c;
    logic [7:0] bus_address_select;
    logic [7:0] fault_enable_first;
    logic [7:0] fault_enable_second;
  } msio_nv_type;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } msio_acc_type;

  typedef struct packed {
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic supply_prev;
    logic recalled;
    logic not_ready;
    logic [CNT_W-1:0] ready_cnt;
    msio_nv_type shadow;
    logic rate_select_input_soft;
    logic [NUM_ALARMS-1:0] alarm_latch;
    logic [7:0] rdata;
    logic [7:0] bus_addr;
    logic [1:0] loss_oe;
    logic gen_oe;
    logic rate_select_input_oe;
    logic fault;
    logic analog_en;
  } msio_state_type;
endpackage : msio_pkg

// file: rtl/msio_status_io.sv
// Status, loss routing, digital I/O, fault and die identification logic.
// Summary of operation
// - Not-ready flag set below analog level, cleared within 500 us after rising above.
// - Answer at fixed default bus address until stored address is recalled.
// - Loss select zero routes the receiver loss pin to the loss output.
// - Loss mux output is readable as the receive-loss status bit.
// - Loss invert bit set inverts the loss signal before the output.
// - Loss select one takes the internal low quick-trip alarm instead.
// - Stored loss selection applies only after analog level and recall.
// - Status byte reports general input and rate-select input levels.
// - General output takes one input chosen by a config bit, forceable and invertible.
// - Rate-select output driven and inverted by status bit and config bit.
// - The loss, general and rate-select open-drain outputs derive from inputs and control settings.
// - Fault asserts on any enabled alarm, warning or quick-trip.
// - Each fault source passes only with its bit set in the enable registers.
// - Each alarm is latched or passed through per config latch bits.
// - Two read-only registers return part code and silicon revision.
// - On reaching analog level, enable analog; stored settings are recalled only on the first time after reset.
// - Outputs stay disabled while supply is below the analog level.
`timescale 1ns/1ps
module msio_status_io #(
  parameter int READY_CYCLES = msio_pkg::READY_CYCLES,
  // Arbitrary identification values.
  parameter logic [7:0] PART_ID = 8'h5a,
  parameter logic [7:0] SI_REV = 8'h01
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_supply_ok,
  input wire msio_pkg::msio_nv_type i_nv,
  input wire msio_pkg::msio_acc_type i_acc,
  input wire logic [1:0] i_loss_pin,
  input wire logic [1:0] i_loss_low_qt,
  input wire logic i_gen_in,
  input wire logic i_rate_sel_in,
  input wire logic [msio_pkg::NUM_FAULT_SRC-1:0] i_fault_src,
  output logic [7:0] o_rdata,
  output logic [7:0] o_bus_addr,
  output logic [1:0] o_loss_out,
  output logic [1:0] o_loss_oe,
  output logic o_gen_out,
  output logic o_gen_oe,
  output logic o_rate_select_input_out,
  output logic o_rate_select_input_oe,
  output logic o_fault,
  output logic o_analog_en
);

  msio_pkg::msio_state_type st_reg;
  msio_pkg::msio_state_type st_next;

  // Pin levels after the second synchroniser stage.
  logic supply_s;
  logic [1:0] loss_pin_s;
  logic gen_in_s;
  logic rate_select_input_in_s;
  logic powered;
  logic [1:0] loss_sel;
  logic [1:0] loss_mux;
  logic [1:0] loss_drive;
  logic gen_val;
  logic rate_select_input_val;
  logic [msio_pkg::NUM_ALARMS-1:0] latch_en;
  logic [msio_pkg::NUM_ALARMS-1:0] alarm_eff;
  logic [msio_pkg::NUM_FAULT_SRC-1:0] fault_vec;
  logic [msio_pkg::NUM_FAULT_SRC-1:0] fault_en;
  logic latch_clr;
  logic [7:0] status_byte;

  function automatic logic [7:0] read_mux(input logic [7:0] addr, input logic [7:0] status,
                                          input msio_pkg::msio_nv_type sh);
    logic [7:0] r;
    r = msio_pkg::RESET_BYTE;
    if (addr == msio_pkg::ADDR_STATUS) begin
      r = status;
    end else if (addr == msio_pkg::ADDR_PART_ID) begin
      r = PART_ID;
    end else if (addr == msio_pkg::ADDR_SI_REV) begin
      r = SI_REV;
    end else if (addr == msio_pkg::ADDR_CONFIG_A) begin
      r = sh.config_a;
    end else if (addr == msio_pkg::ADDR_CONFIG_B) begin
      r = sh.config_b;
    end else if (addr == msio_pkg::ADDR_CONFIG_C) begin
      r = sh.config_c;
    end else if (addr == msio_pkg::ADDR_BUS_SEL) begin
      r = sh.bus_address_select;
    end else if (addr == msio_pkg::ADDR_FAULT_EN1) begin
      r = sh.fault_enable_first;
    end else if (addr == msio_pkg::ADDR_FAULT_EN2) begin
      r = sh.fault_enable_second;
    end
    return r;
  endfunction : read_mux

  assign supply_s = st_reg.sync2[0];
  assign loss_pin_s = st_reg.sync2[2:1];
  assign gen_in_s = st_reg.sync2[3];
  assign rate_select_input_in_s = st_reg.sync2[4];
  // Recalled settings act only while the analog level is held.
  assign powered = supply_s & st_reg.recalled;

  // Until recall the stored mux choice is not trusted, so the pin path is used.
  assign loss_sel = powered ? st_reg.shadow.config_c[msio_pkg::CC_LOSS_SEL +: 2] : 2'b00;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_loss
      assign loss_mux[g] = loss_sel[g] ? i_loss_low_qt[g] : loss_pin_s[g];
      assign loss_drive[g] = loss_mux[g] ^ st_reg.shadow.config_c[msio_pkg::CC_LOSS_INV + g];
    end
  endgenerate

  // General output: chosen input, optionally forced, then optionally inverted.
  always_comb begin
    gen_val = st_reg.shadow.config_b[msio_pkg::CB_GEN_SRC] ? rate_select_input_in_s : gen_in_s;
    if (st_reg.shadow.config_b[msio_pkg::CB_GEN_FORCE]) begin
      gen_val = st_reg.shadow.config_b[msio_pkg::CB_GEN_FVAL];
    end
    gen_val = gen_val ^ st_reg.shadow.config_b[msio_pkg::CB_GEN_INV];
  end

  // Rate-select output: software bit, optionally or-ed with the pin, then optionally inverted.
  assign rate_select_input_val = (st_reg.rate_select_input_soft | (st_reg.shadow.config_a[msio_pkg::CA_RATE_SELECT_INPUT_PIN] & rate_select_input_in_s))
                    ^ st_reg.shadow.config_a[msio_pkg::CA_RATE_SELECT_INPUT_INV];

  assign latch_en = {st_reg.shadow.config_c[msio_pkg::CC_LATCH_LO +: 2],
                     st_reg.shadow.config_b[msio_pkg::CB_LATCH_LO +: 4]};
  assign fault_en = {st_reg.shadow.fault_enable_second, st_reg.shadow.fault_enable_first};

  // Latched alarms add to the live ones so a cleared condition still faults.
  assign alarm_eff = i_fault_src[msio_pkg::NUM_ALARMS-1:0]
                     | (st_reg.alarm_latch & latch_en);

  always_comb begin
    fault_vec = i_fault_src;
    fault_vec[msio_pkg::NUM_ALARMS-1:0] = alarm_eff;
    fault_vec[msio_pkg::FS_LOSS_QT +: 2] = i_fault_src[msio_pkg::FS_LOSS_QT +: 2] | i_loss_low_qt;
  end

  assign latch_clr = i_acc.wr && (i_acc.addr == msio_pkg::ADDR_STATUS)
                     && i_acc.wdata[msio_pkg::ST_LATCH_CLR];

  always_comb begin
    status_byte = msio_pkg::RESET_BYTE;
    status_byte[msio_pkg::ST_NOT_READY] = st_reg.not_ready;
    status_byte[msio_pkg::ST_RXL0] = loss_mux[0];
    status_byte[msio_pkg::ST_RXL1] = loss_mux[1];
    status_byte[msio_pkg::ST_LATCH_CLR] = |st_reg.alarm_latch;
    status_byte[msio_pkg::ST_RATE_SELECT_INPUT_SOFT] = st_reg.rate_select_input_soft;
    status_byte[msio_pkg::ST_GEN_IN] = gen_in_s;
    status_byte[msio_pkg::ST_RATE_SELECT_INPUT_IN] = rate_select_input_in_s;
  end

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = {i_rate_sel_in, i_gen_in, i_loss_pin, i_supply_ok};
    st_next.sync2 = st_reg.sync1;
    st_next.supply_prev = supply_s;

    // Stored settings are reloaded once per digital power-up; a dip that
    // stays above the digital level keeps them.
    if (supply_s && !st_reg.supply_prev && !st_reg.recalled) begin
      st_next.shadow = i_nv;
      st_next.recalled = 1'b1;
    end else if (i_acc.wr) begin
      if (i_acc.addr == msio_pkg::ADDR_STATUS) begin
        st_next.rate_select_input_soft = i_acc.wdata[msio_pkg::ST_RATE_SELECT_INPUT_SOFT];
      end else if (i_acc.addr == msio_pkg::ADDR_CONFIG_A) begin
        st_next.shadow.config_a = i_acc.wdata;
      end else if (i_acc.addr == msio_pkg::ADDR_CONFIG_B) begin
        st_next.shadow.config_b = i_acc.wdata;
      end else if (i_acc.addr == msio_pkg::ADDR_CONFIG_C) begin
        st_next.shadow.config_c = i_acc.wdata;
      end else if (i_acc.addr == msio_pkg::ADDR_BUS_SEL) begin
        st_next.shadow.bus_address_select = i_acc.wdata;
      end else if (i_acc.addr == msio_pkg::ADDR_FAULT_EN1) begin
        st_next.shadow.fault_enable_first = i_acc.wdata;
      end else if (i_acc.addr == msio_pkg::ADDR_FAULT_EN2) begin
        st_next.shadow.fault_enable_second = i_acc.wdata;
      end
    end

    // Not-ready timing restarts on every fall below the analog level.
    // The count stops three edges short to pay for the pin synchroniser and the flag register.
    if (!supply_s) begin
      st_next.not_ready = 1'b1;
      st_next.ready_cnt = '0;
    end else if (st_reg.not_ready) begin
      if (st_reg.ready_cnt >= msio_pkg::CNT_W'(READY_CYCLES - 3)) begin
        st_next.not_ready = 1'b0;
      end else begin
        st_next.ready_cnt = st_reg.ready_cnt + 1'b1;
      end
    end

    // A new alarm in the clearing cycle survives the clear.
    st_next.alarm_latch = ((st_reg.alarm_latch & {msio_pkg::NUM_ALARMS{~latch_clr}})
                           | i_fault_src[msio_pkg::NUM_ALARMS-1:0]) & latch_en;

    st_next.rdata = read_mux(i_acc.addr, status_byte, st_reg.shadow);
    st_next.bus_addr = st_reg.recalled ? st_reg.shadow.bus_address_select
                                       : msio_pkg::DEFAULT_BUS_ADDR;

    // Open-drain pins pull low when the driven value is low.
    st_next.loss_oe = powered ? ~loss_drive : 2'b00;
    st_next.gen_oe = powered & ~gen_val;
    st_next.rate_select_input_oe = powered & ~rate_select_input_val;
    st_next.fault = powered & |(fault_vec & fault_en);
    st_next.analog_en = powered;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.not_ready <= 1'b1;
      st_reg.bus_addr <= msio_pkg::DEFAULT_BUS_ADDR;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata = st_reg.rdata;
  assign o_bus_addr = st_reg.bus_addr;
  assign o_loss_out = 2'b00;
  assign o_loss_oe = st_reg.loss_oe;
  assign o_gen_out = 1'b0;
  assign o_gen_oe = st_reg.gen_oe;
  assign o_rate_select_input_out = 1'b0;
  assign o_rate_select_input_oe = st_reg.rate_select_input_oe;
  assign o_fault = st_reg.fault;
  assign o_analog_en = st_reg.analog_en;

endmodule : msio_status_io

// file: verification/msio_chk.sv
// Port checker for the status and I/O block.
`timescale 1ns/1ps
module msio_chk #(
  parameter logic [7:0] PART_ID = 8'h5a,
  parameter logic [7:0] SI_REV = 8'h01
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_supply_ok,
  input wire msio_pkg::msio_acc_type i_acc,
  input wire logic i_gen_in,
  input wire logic i_rate_sel_in,
  input wire logic [7:0] o_rdata,
  input wire logic [7:0] o_bus_addr,
  input wire logic [1:0] o_loss_out,
  input wire logic [1:0] o_loss_oe,
  input wire logic o_gen_out,
  input wire logic o_gen_oe,
  input wire logic o_rate_select_input_out,
  input wire logic o_rate_select_input_oe,
  input wire logic o_analog_en
);
  // Remembers the first enable, since a supply dip keeps the recalled address.
  logic seen_reg;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) seen_reg <= 1'b0;
    else if (o_analog_en) seen_reg <= 1'b1;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  outputs_off_a: assert property ((!i_supply_ok)[*5] |-> !o_analog_en && o_loss_oe == 2'b00)
    else $error("outputs active below supply level");
  outs_tied_a: assert property (!o_analog_en |-> o_loss_oe == 2'b00 && !o_gen_oe && !o_rate_select_input_oe)
    else $error("output enabled while analog is off");
  not_ready_a: assert property ((!i_supply_ok && i_acc.addr == msio_pkg::ADDR_STATUS)[*5] |=> o_rdata[0])
    else $error("not-ready flag clear at low supply");
  default_addr_a: assert property (!seen_reg && !o_analog_en |-> o_bus_addr == msio_pkg::DEFAULT_BUS_ADDR)
    else $error("bus address not default before recall");
  part_id_a: assert property (i_acc.addr == msio_pkg::ADDR_PART_ID |=> o_rdata == PART_ID)
    else $error("part code wrong");
  si_rev_a: assert property (i_acc.addr == msio_pkg::ADDR_SI_REV |=> o_rdata == SI_REV)
    else $error("revision wrong");
  in_level_a: assert property ((i_acc.addr == msio_pkg::ADDR_STATUS && $stable(i_gen_in)
    && $stable(i_rate_sel_in))[*4] |=> o_rdata[7:6] == {$past(i_rate_sel_in), $past(i_gen_in)})
    else $error("input levels not in status");
  readback_a: assert property (o_analog_en && i_acc.wr && i_acc.addr == msio_pkg::ADDR_CONFIG_A ##1
    i_acc.addr == msio_pkg::ADDR_CONFIG_A |=> o_rdata == $past(i_acc.wdata, 2))
    else $error("config readback wrong");
  od_data_a: assert property (o_loss_out == 2'b00 && !o_gen_out && !o_rate_select_input_out)
    else $error("open-drain data not low");
endmodule : msio_chk

// file: verification/msio_host_model.sv
// Behavioural host that reaches the registers through the access port.
`timescale 1ns/1ps
module msio_host_model (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  output msio_pkg::msio_acc_type o_acc
);
  initial o_acc = '{wr: 1'b0, addr: msio_pkg::ADDR_STATUS, wdata: 8'h00};
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_mclk);
    o_acc = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge i_mclk);
    o_acc.wr = 1'b0;
  endtask : wr
  // Two edges cover a write just before, as readback lags by two.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_acc.addr = a;
    repeat (2) @(negedge i_mclk);
    d = i_rdata;
  endtask : rd
  task automatic wait_ready(input int lim, output logic ok);
    logic [7:0] d;
    ok = 1'b0;
    for (int n = 0; n < lim && !ok; n++) begin
      rd(msio_pkg::ADDR_STATUS, d);
      ok = (d[msio_pkg::ST_NOT_READY] === 1'b0);
    end
  endtask : wait_ready
endmodule : msio_host_model

// file: verification/tb_msio_status_io.sv
// Self-checking bench for the status and I/O block.
`timescale 1ns/1ps
module tb_msio_status_io;
  localparam int RDY = 20;
  localparam logic [7:0] PART_ID = 8'h3c; // Arbitrary value.
  localparam logic [7:0] SI_REV = 8'h07; // Arbitrary value.
  logic i_mclk = 1'b0, i_rst = 1'b1, i_supply_ok = 1'b0, i_gen_in = 1'b0, i_rate_sel_in = 1'b0, ok;
  logic [1:0] i_loss_pin = 2'b00, i_loss_low_qt = 2'b00, o_loss_out, o_loss_oe, mx, lx;
  logic [15:0] i_fault_src = 16'h0000;
  logic [7:0] o_rdata, o_bus_addr, rd_val;
  logic o_gen_out, o_gen_oe, o_rate_select_input_out, o_rate_select_input_oe, o_fault, o_analog_en;
  msio_pkg::msio_nv_type i_nv = 48'h0000_03a6_0000;
  msio_pkg::msio_acc_type i_acc;
  int bad_count = 0, cmp_count = 0, seed = 2494;
  always #12.5 i_mclk = ~i_mclk;
  msio_host_model i_host (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_acc(i_acc));
  msio_status_io #(.READY_CYCLES(RDY), .PART_ID(PART_ID), .SI_REV(SI_REV)) i_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_supply_ok(i_supply_ok), .i_nv(i_nv), .i_acc(i_acc),
    .i_loss_pin(i_loss_pin), .i_loss_low_qt(i_loss_low_qt), .i_gen_in(i_gen_in),
    .i_rate_sel_in(i_rate_sel_in), .i_fault_src(i_fault_src), .o_rdata(o_rdata), .o_bus_addr(o_bus_addr),
    .o_loss_out(o_loss_out), .o_loss_oe(o_loss_oe), .o_gen_out(o_gen_out), .o_gen_oe(o_gen_oe),
    .o_rate_select_input_out(o_rate_select_input_out), .o_rate_select_input_oe(o_rate_select_input_oe), .o_fault(o_fault), .o_analog_en(o_analog_en));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic bail(input string nm, input logic c);
    if (c !== 1'b1) begin
      chk(nm, 8'h01, 8'h00);
      test_done();
    end
  endtask : bail
  function automatic logic gen_val(input logic [7:0] b, input logic g, input logic r);
    return (b[0] ? b[1] : (b[3] ? r : g)) ^ b[2];
  endfunction : gen_val
  initial begin
    logic [7:0] ca, cb, cc, st;
    logic [15:0] en;
    repeat (3) @(negedge i_mclk);
    i_rst = 1'b0;
    i_loss_pin = 2'b10;
    i_loss_low_qt = 2'b01;
    repeat (6) @(negedge i_mclk);
    chk("bus_addr", 8'ha2, o_bus_addr);
    chk("outs", 8'h00, {3'h0, o_analog_en, o_loss_oe, o_gen_oe, o_rate_select_input_oe});
    i_host.rd(msio_pkg::ADDR_STATUS, rd_val);
    chk("status", 8'h05, rd_val);
    i_supply_ok = 1'b1;
    for (int n = 0; n < 10 && o_analog_en !== 1'b1; n++) @(negedge i_mclk);
    bail("analog_en", o_analog_en);
    chk("bus_addr", 8'ha6, o_bus_addr);
    i_host.wait_ready(RDY / 3 + 4, ok);
    bail("ready", ok);
    $display("Test power-up done");
    for (int i = 0; i < 40; i++) begin
      ca = 8'($random(seed)) & 8'h03;
      cb = 8'($random(seed)) & 8'h0f;
      cc = 8'($random(seed)) & 8'h0f;
      en = 16'($random(seed));
      st = 8'($random(seed)) & 8'h20;
      i_host.wr(msio_pkg::ADDR_CONFIG_A, ca);
      i_host.wr(msio_pkg::ADDR_CONFIG_B, cb);
      i_host.wr(msio_pkg::ADDR_CONFIG_C, cc);
      i_host.wr(msio_pkg::ADDR_FAULT_EN1, en[7:0]);
      i_host.wr(msio_pkg::ADDR_FAULT_EN2, en[15:8]);
      i_host.wr(msio_pkg::ADDR_STATUS, st);
      {i_loss_pin, i_loss_low_qt, i_gen_in, i_rate_sel_in} = 6'($random(seed));
      i_fault_src = 16'($random(seed)) & 16'h3fff;
      repeat (3) @(negedge i_mclk);
      i_host.rd(msio_pkg::ADDR_STATUS, rd_val);
      mx = (cc[1:0] & i_loss_low_qt) | (~cc[1:0] & i_loss_pin);
      lx = ~(mx ^ cc[3:2]);
      chk("loss_oe", {6'h00, lx}, {6'h00, o_loss_oe});
      chk("status", {i_rate_sel_in, i_gen_in, st[5], 2'b00, mx, 1'b0}, rd_val);
      chk("gen_oe", {7'h00, ~gen_val(cb, i_gen_in, i_rate_sel_in)}, {7'h00, o_gen_oe});
      chk("rate_select_input_oe", {7'h00, ~((st[5] | (ca[1] & i_rate_sel_in)) ^ ca[0])}, {7'h00, o_rate_select_input_oe});
      chk("fault", {7'h00, |((i_fault_src | {2'b00, i_loss_low_qt, 12'h000}) & en)}, {7'h00, o_fault});
    end
    $display("Test random io done");
    i_host.wr(msio_pkg::ADDR_FAULT_EN1, 8'h01);
    i_host.wr(msio_pkg::ADDR_FAULT_EN2, 8'h00);
    i_host.wr(msio_pkg::ADDR_CONFIG_B, 8'h10);
    i_fault_src = 16'h0001;
    @(negedge i_mclk);
    i_fault_src = 16'h0000;
    repeat (2) @(negedge i_mclk);
    chk("fault_held", 8'h01, {7'h00, o_fault});
    i_host.rd(msio_pkg::ADDR_STATUS, rd_val);
    chk("latch_flag", 8'h08, rd_val & 8'h08);
    i_host.wr(msio_pkg::ADDR_STATUS, 8'h08);
    repeat (2) @(negedge i_mclk);
    chk("fault_clr", 8'h00, {7'h00, o_fault});
    // An alarm present in the clearing cycle must survive the clear.
    i_fault_src = 16'h0001;
    i_host.wr(msio_pkg::ADDR_STATUS, 8'h08);
    i_fault_src = 16'h0000;
    repeat (2) @(negedge i_mclk);
    chk("set_wins", 8'h01, {7'h00, o_fault});
    $display("Test latch done");
    i_host.wr(msio_pkg::ADDR_PART_ID, 8'hff);
    i_host.rd(msio_pkg::ADDR_PART_ID, rd_val);
    chk("part_id", PART_ID, rd_val);
    i_host.rd(msio_pkg::ADDR_SI_REV, rd_val);
    chk("si_rev", SI_REV, rd_val);
    i_host.rd(8'h00, rd_val);
    chk("unmapped", 8'h00, rd_val);
    i_supply_ok = 1'b0;
    repeat (5) @(negedge i_mclk);
    chk("dip_outs", 8'ha6, o_analog_en ? 8'h00 : o_bus_addr);
    // Recovery above the analog level keeps host settings, with no second recall.
    i_supply_ok = 1'b1;
    for (int n = 0; n < 10 && o_analog_en !== 1'b1; n++) @(negedge i_mclk);
    chk("resume", 8'h01, {7'h00, o_analog_en});
    i_host.rd(msio_pkg::ADDR_CONFIG_B, rd_val);
    chk("no_rerecall", 8'h10, rd_val);
    $display("Test dip done");
    // A digital reset in mid-run brings back the default address and a fresh recall.
    i_supply_ok = 1'b0;
    i_rst = 1'b1;
    @(negedge i_mclk);
    chk("rst_addr", 8'ha2, o_bus_addr);
    i_rst = 1'b0;
    i_supply_ok = 1'b1;
    for (int n = 0; n < 10 && o_analog_en !== 1'b1; n++) @(negedge i_mclk);
    bail("analog_en", o_analog_en);
    chk("bus_addr", 8'ha6, o_bus_addr);
    i_host.rd(msio_pkg::ADDR_STATUS, rd_val);
    chk("not_ready", 8'h01, rd_val & 8'h01);
    i_host.rd(msio_pkg::ADDR_CONFIG_B, rd_val);
    chk("recall_b", 8'h00, rd_val);
    $display("Test reset done");
    test_done();
  end
endmodule : tb_msio_status_io
bind msio_status_io msio_chk #(.PART_ID(PART_ID), .SI_REV(SI_REV)) i_chk (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_supply_ok(i_supply_ok), .i_acc(i_acc), .i_gen_in(i_gen_in),
  .i_rate_sel_in(i_rate_sel_in), .o_rdata(o_rdata), .o_bus_addr(o_bus_addr), .o_loss_out(o_loss_out),
  .o_loss_oe(o_loss_oe), .o_gen_out(o_gen_out), .o_gen_oe(o_gen_oe), .o_rate_select_input_out(o_rate_select_input_out),
  .o_rate_select_input_oe(o_rate_select_input_oe), .o_analog_en(o_analog_en));
